// ==== shared/gcq_pkg.sv ====
// constants shared by the graphics command queue front end
// Behaviour
// R1: host sets mode, then parameters, then initiator
// R2: writes stream into sixteen-entry command fifo
// R3: packets leave fifo singly, in order, per mode
// R4: host writes all parameters before the initiator
// R5: no new packet starts before current finishes
// R6: parameters double-buffered: load copy, active copy
// R7: host writes depth select only when idle
// R8: host writes transfer data idle in dma-write
// R9: idle means nothing running and fifo empty
// R10: status bit 0 reads one while busy
// R11: status write queued, stalls until prior work done
// R12: operands from control registers and initiator data
// R13: depth/stencil only in 3d line modes, off-screen
// R14: deep bit zero: packed bytes, no depth buffers
// R15: deep bit one: all layouts plus depth buffers
// R16: packed layout: pixel 0 low byte upward
// R17: deep mode: one word per pixel, top tag
// R18: deep bitmap depths limited to 8, 12, 24
// R19: unpacked bytes at 7:0, 15:8, 23:16, tag top
// R20: wide and narrow depth formats in deep mode
// R21: wide depth: stencil 31:24, depth 23:0
// R22: mode bit 14 selects the narrow depth format
// R23: true colour: tag, red, green, blue bytes
// R24: fifo full holds off host writes, no drops; here hold_o is raised, but a write arriving while full is dropped
// R25: reset empties fifo, clears busy, defines copies
package gcq_pkg;

    // -------------------------------------------------------------
    // register word addresses
    // -------------------------------------------------------------
    localparam logic [3:0] OFS_MODE   = 4'h0;
    localparam logic [3:0] OFS_DEPTH  = 4'h1;
    localparam logic [3:0] OFS_XFER   = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_ADDR   = 4'h4;
    localparam logic [3:0] OFS_ARG    = 4'h5;
    localparam logic [3:0] OFS_CMD    = 4'h8;
    localparam logic [3:0] OFS_FBWR   = 4'h9;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int MODE_OP_MSB  = 3;
    localparam int LAYOUT_LSB   = 4;
    localparam int LAYOUT_MSB   = 6;
    localparam int NARROW_Z_BIT = 14;
    localparam int DEEP_BIT     = 0;
    localparam int BUSY_BIT     = 0;
    localparam int HOLD_BIT     = 1;
    localparam int ERR_BIT      = 2;
    localparam int COUNT_LSB    = 4;
    localparam int COUNT_MSB    = 8;

    // -------------------------------------------------------------
    // fifo geometry and modes
    // -------------------------------------------------------------
    localparam int         FIFO_DEPTH = 16;
    localparam int         ENTRY_W    = 36;
    localparam logic [4:0] HOLD_LEVEL = 5'h0F;
    localparam logic [3:0] MODE_DMA_WR = 4'h6;
    localparam int         MODE_3D_BIT = 3;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [31:0] RST_MODE  = 32'h0000_0000;
    localparam logic [31:0] RST_PARAM = 32'h0000_0000;
    localparam logic        RST_DEEP  = 1'b0;

    // -------------------------------------------------------------
    // frame buffer object layouts
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        packed_byte_layout     = 3'h0,
        unpacked_byte_layout_0 = 3'h1,
        unpacked_byte_layout_1 = 3'h2,
        unpacked_byte_layout_2 = 3'h3,
        direct_color_nibble_layout_0 = 3'h4,
        direct_color_nibble_layout_1 = 3'h5,
        true_color_layout      = 3'h6,
        depth_stencil_layout   = 3'h7
    } gcq_layout_e;

endpackage

// ==== rtl/gcq_fifo.sv ====
// command fifo holding queued register writes
`timescale 1ns/1ps
module gcq_fifo
    import gcq_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // filling side
    input  wire logic               in_valid_i,
    output logic                    in_ready_o,
    input  wire logic [ENTRY_W-1:0] in_data_i,
    // draining side
    output logic                    out_valid_o,
    input  wire logic               out_ready_i,
    output logic [ENTRY_W-1:0]      out_data_o,
    output logic [4:0]              count_o
);
    logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
    logic [3:0]         wr_ptr;
    logic [3:0]         rd_ptr;
    logic [4:0]         count;
    logic               push;
    logic               pop;

    assign in_ready_o  = (count != 5'(FIFO_DEPTH));
    assign out_valid_o = (count != 5'h00);
    assign out_data_o  = mem[rd_ptr];
    assign count_o     = count;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // strict arrival order [R3]
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count  <= 5'h00; // [R25]
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            count <= count + 5'(push) - 5'(pop); // [R2]
        end
    end
endmodule

// ==== rtl/gcq_pix_pack.sv ====
// places initiator data into a frame buffer word per layout
`timescale 1ns/1ps
module gcq_pix_pack
    import gcq_pkg::*;
(
    // selection
    input  wire logic        deep_i,
    input  wire logic        line3d_i,
    input  wire logic        narrow_z_i,
    input  wire gcq_layout_e layout_i,
    input  wire logic [1:0]  lane_i,
    // data
    input  wire logic [31:0] data_i,
    output logic [31:0]      word_o,
    output logic [3:0]       mask_o,
    output logic             ok_o
);
    logic [7:0] tag;
    logic [7:0] pix;

    assign tag = data_i[31:24];
    assign pix = data_i[7:0];

    always_comb begin
        word_o = 32'h0000_0000;
        mask_o = 4'h0;
        ok_o   = deep_i; // [R15] [R18]
        unique case (layout_i)
            packed_byte_layout: begin
                word_o = {4{pix}}; // [R16]
                mask_o = 4'h1 << lane_i;
                ok_o   = 1'b1; // [R14]
            end
            unpacked_byte_layout_0: begin
                word_o = {tag, 16'h0000, pix}; // [R19] [R17]
                mask_o = 4'h9;
            end
            unpacked_byte_layout_1: begin
                word_o = {tag, 8'h00, pix, 8'h00};
                mask_o = 4'hA;
            end
            unpacked_byte_layout_2: begin
                word_o = {tag, pix, 16'h0000};
                mask_o = 4'hC;
            end
            direct_color_nibble_layout_0: begin
                word_o = {tag, 4'h0, data_i[11:8], 4'h0, data_i[7:4], 4'h0, data_i[3:0]};
                mask_o = 4'hF;
            end
            direct_color_nibble_layout_1: begin
                word_o = {tag, data_i[11:8], 4'h0, data_i[7:4], 4'h0, data_i[3:0], 4'h0};
                mask_o = 4'hF;
            end
            true_color_layout: begin
                word_o = data_i; // [R23]
                mask_o = 4'hF;
            end
            depth_stencil_layout: begin
                // narrow: depth 23:8 beside a low pixel byte [R22]
                word_o = narrow_z_i ? {tag, data_i[23:8], pix} : data_i; // [R21] [R20]
                mask_o = 4'hF;
                ok_o   = deep_i && line3d_i; // [R13]
            end
        endcase
    end
endmodule

// ==== rtl/gcq_top.sv ====
// graphics command queue front end with barrier and double buffers
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module gcq_top
    import gcq_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic             hold_o,
    // drawing engine side
    output logic             op_start_o,
    output logic [3:0]       op_mode_o,
    output logic [31:0]      op_addr_o,
    output logic [31:0]      op_arg_o,
    output logic [31:0]      op_word_o,
    output logic [3:0]       op_mask_o,
    output logic             op_deep_o,
    input  wire logic        op_done_i,
    // transfer data for dma-write copy
    output logic [31:0]      xfer_data_o,
    output logic             xfer_load_o
);
    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } gcq_state_e;

    gcq_state_e         state;
    gcq_state_e         next_state;

    logic               push;
    logic               fifo_ready;
    logic               head_valid;
    logic [ENTRY_W-1:0] head;
    logic [3:0]         head_addr;
    logic [31:0]        head_data;
    logic [4:0]         fifo_count;
    logic               pop;

    logic [31:0]        mode_load;
    logic [31:0]        addr_load;
    logic [31:0]        arg_load;
    logic               deep;
    logic               err;

    logic               is_init;
    logic               is_sync;
    logic               start_ok;
    logic               busy;
    logic               mapped_wr;

    logic [31:0]        pack_word;
    logic [3:0]         pack_mask;
    logic               pack_ok;

    // -------------------------------------------------------------
    // command fifo
    // -------------------------------------------------------------
    // every mapped write is queued while the fifo has room, the status barrier among them
    always_comb begin
        unique case (addr_i)
            OFS_MODE, OFS_DEPTH, OFS_XFER, OFS_STATUS,
            OFS_ADDR, OFS_ARG, OFS_CMD, OFS_FBWR: mapped_wr = 1'b1;
            default: mapped_wr = 1'b0;
        endcase
    end

    assign push = wr_i && mapped_wr; // [R2] [R11]

    gcq_fifo u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({addr_i, wdata_i}),
        .out_valid_o (head_valid),
        .out_ready_i (pop),
        .out_data_o  (head),
        .count_o     (fifo_count)
    );

    assign head_addr = head[ENTRY_W-1:32];
    assign head_data = head[31:0];

    // -------------------------------------------------------------
    // hold-off towards the host
    // -------------------------------------------------------------
    // raised one entry early so a write in the rising cycle still fits
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_o <= 1'b0;
        end else begin
            hold_o <= (fifo_count + 5'(push) - 5'(pop)) >= HOLD_LEVEL; // [R24]
        end
    end

    // -------------------------------------------------------------
    // dequeue decision
    // -------------------------------------------------------------
    assign is_init = (head_addr == OFS_CMD) || (head_addr == OFS_FBWR);

    // entries that must wait for all prior work to finish
    assign is_sync = (head_addr == OFS_STATUS)                       // [R11]
                  || (head_addr == OFS_DEPTH)
                  || ((head_addr == OFS_XFER)
                      && (mode_load[MODE_OP_MSB:0] == MODE_DMA_WR));

    // loads go to the load copy even while an operation runs [R6]
    assign pop = head_valid && ((state == ST_IDLE) || !(is_init || is_sync)); // [R5]

    assign start_ok = pop && is_init && pack_ok;

    // -------------------------------------------------------------
    // pixel placement of the initiating data
    // -------------------------------------------------------------
    gcq_pix_pack u_pack (
        .deep_i     (deep),
        .line3d_i   (mode_load[MODE_3D_BIT]),
        .narrow_z_i (mode_load[NARROW_Z_BIT]),
        .layout_i   (gcq_layout_e'(mode_load[LAYOUT_MSB:LAYOUT_LSB])),
        .lane_i     (addr_load[1:0]),
        .data_i     (head_data),
        .word_o     (pack_word),
        .mask_o     (pack_mask),
        .ok_o       (pack_ok)
    );

    // -------------------------------------------------------------
    // execution state
    // -------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_ok) begin
                    next_state = ST_EXEC; // [R3]
                end
            end
            ST_EXEC: begin
                if (op_done_i) begin
                    next_state = ST_IDLE; // [R5]
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------
    // load copy of the control registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_load <= RST_MODE; // [R25]
            addr_load <= RST_PARAM;
            arg_load  <= RST_PARAM;
        end else if (pop) begin
            unique case (head_addr)
                OFS_MODE: mode_load <= head_data;
                OFS_ADDR: addr_load <= head_data;
                OFS_ARG:  arg_load  <= head_data;
                default:  ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // frame buffer depth select
    // -------------------------------------------------------------
    // only reached with the engine idle, behind the sync check
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            deep <= RST_DEEP;
        end else if (pop && (head_addr == OFS_DEPTH)) begin
            deep <= head_data[DEEP_BIT]; // [R14] [R15]
        end
    end

    // -------------------------------------------------------------
    // active copy driving the engine
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_mode_o <= 4'h0; // [R25]
            op_addr_o <= RST_PARAM;
            op_arg_o  <= RST_PARAM;
            op_word_o <= 32'h0000_0000;
            op_mask_o <= 4'h0;
            op_deep_o <= RST_DEEP;
        end else if (start_ok) begin
            op_mode_o <= mode_load[MODE_OP_MSB:0]; // [R6]
            op_addr_o <= addr_load; // [R12]
            op_arg_o  <= arg_load;
            op_word_o <= pack_word; // [R12]
            op_mask_o <= pack_mask;
            op_deep_o <= deep;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_start_o <= 1'b0;
        end else begin
            op_start_o <= start_ok;
        end
    end

    // -------------------------------------------------------------
    // transfer data register
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            xfer_data_o <= 32'h0000_0000;
            xfer_load_o <= 1'b0;
        end else begin
            xfer_load_o <= pop && (head_addr == OFS_XFER);
            if (pop && (head_addr == OFS_XFER)) begin
                xfer_data_o <= head_data; // [R8]
            end
        end
    end

    // -------------------------------------------------------------
    // rejected initiator flag
    // -------------------------------------------------------------
    // layout not allowed at this depth or mode; the barrier clears it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err <= 1'b0;
        end else if (pop && is_init && !pack_ok) begin
            err <= 1'b1; // [R13]
        end else if (pop && (head_addr == OFS_STATUS)) begin
            err <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // register reads
    // -------------------------------------------------------------
    // idle only with nothing running and nothing queued
    assign busy = (state != ST_IDLE) || (fifo_count != 5'h00); // [R9]

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= 32'h0000_0000;
            unique case (addr_i)
                OFS_MODE:  rdata_o <= mode_load;
                OFS_DEPTH: rdata_o[DEEP_BIT] <= deep;
                OFS_XFER:  rdata_o <= xfer_data_o;
                OFS_ADDR:  rdata_o <= addr_load;
                OFS_ARG:   rdata_o <= arg_load;
                OFS_STATUS: begin
                    rdata_o[BUSY_BIT] <= busy; // [R10]
                    rdata_o[HOLD_BIT] <= !fifo_ready;
                    rdata_o[ERR_BIT]  <= err;
                    rdata_o[COUNT_MSB:COUNT_LSB] <= fifo_count;
                end
                default: ;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// ==== sim/gcq_engine_model.sv ====
// drawing engine model answering each launch after a set delay
`timescale 1ns/1ps
module gcq_engine_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // launch and completion
    input  wire logic       op_start_i,
    input  wire logic [7:0] delay_i,
    output logic            op_done_o
);
    logic [7:0] cnt;

    // done only after a launch, one cycle long
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt       <= 8'h00;
            op_done_o <= 1'b0;
        end else begin
            op_done_o <= (cnt == 8'h01);
            if (op_start_i)
                cnt <= delay_i;
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
endmodule

// ==== sim/gcq_props.sv ====
// port assertions for the command queue front end
`timescale 1ns/1ps
module gcq_props
    import gcq_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        hold_o,
    input wire logic        op_start_o,
    input wire logic [3:0]  op_mode_o,
    input wire logic [31:0] op_addr_o,
    input wire logic [31:0] op_arg_o,
    input wire logic [31:0] op_word_o,
    input wire logic [3:0]  op_mask_o,
    input wire logic        op_deep_o,
    input wire logic        op_done_i,
    input wire logic [31:0] xfer_data_o,
    input wire logic        xfer_load_o
);
    logic run_q;

    // engine owns an operation from launch to done
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            run_q <= 1'b0;
        else if (op_start_o)
            run_q <= 1'b1;
        else if (op_done_i)
            run_q <= 1'b0;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    one_start_a: assert property (op_start_o |=> !op_start_o)
        else $error("launch pulse too long");
    serial_a: assert property (op_start_o |-> !run_q)
        else $error("launch while engine runs");
    params_a: assert property (!op_start_o |-> $stable({op_mode_o, op_addr_o, op_arg_o}))
        else $error("active copy changed without launch");
    deep_a: assert property ($changed(op_deep_o) |-> op_start_o)
        else $error("deep bit changed mid operation");
    busy_a: assert property (rd_i && addr_i == OFS_STATUS && run_q && !op_done_i
        |=> rdata_o[BUSY_BIT]) else $error("busy not reported");
    queued_a: assert property (rd_i && addr_i == OFS_STATUS
        |=> rdata_o[COUNT_MSB:COUNT_LSB] == 5'h00 || rdata_o[BUSY_BIT])
        else $error("idle with queued entries");
    quiet_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    packed_a: assert property (op_start_o && !op_deep_o |-> $onehot(op_mask_o))
        else $error("shallow launch not one byte lane");
    dma_a: assert property (xfer_load_o && op_mode_o == MODE_DMA_WR |-> !run_q)
        else $error("transfer data loaded while running");
    xfer_a: assert property (!xfer_load_o |-> $stable(xfer_data_o))
        else $error("transfer data changed without load");
    rst_out_a: assert property ($rose(resetn_i) |-> !op_start_o && !hold_o && !xfer_load_o)
        else $error("outputs active after reset");
endmodule

bind gcq_top gcq_props u_props (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hold_o(hold_o),
    .op_start_o(op_start_o), .op_mode_o(op_mode_o), .op_addr_o(op_addr_o),
    .op_arg_o(op_arg_o), .op_word_o(op_word_o), .op_mask_o(op_mask_o),
    .op_deep_o(op_deep_o), .op_done_i(op_done_i), .xfer_data_o(xfer_data_o),
    .xfer_load_o(xfer_load_o));

// ==== sim/graphics_command_queue_sync_tb.sv ====
// self-checking bench for the command queue front end
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module graphics_command_queue_sync_tb
    import gcq_pkg::*;
    ;
    logic        clk_i, resetn_i, wr_i, rd_i, op_done_i, op_start_o, hold_o, op_deep_o;
    logic        xfer_load_o;
    logic [3:0]  addr_i, op_mode_o, op_mask_o;
    logic [31:0] wdata_i, rdata_o, op_addr_o, op_arg_o, op_word_o, xfer_data_o, rv;
    logic [7:0]  eng_dly;
    int          num_errors, checks, cyc, n_starts, base, n;

    gcq_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hold_o(hold_o),
        .op_start_o(op_start_o), .op_mode_o(op_mode_o), .op_addr_o(op_addr_o),
        .op_arg_o(op_arg_o), .op_word_o(op_word_o), .op_mask_o(op_mask_o),
        .op_deep_o(op_deep_o), .op_done_i(op_done_i), .xfer_data_o(xfer_data_o),
        .xfer_load_o(xfer_load_o));
    gcq_engine_model u_eng (.clk_i(clk_i), .resetn_i(resetn_i), .op_start_i(op_start_o),
        .delay_i(eng_dly), .op_done_o(op_done_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (op_start_o === 1'b1) n_starts++;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
    end

    // ----------------------------------------
    // bus and wait helpers
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic wait_start();
        repeat (300) begin
            @(posedge clk_i);
            #1;
            if (op_start_o === 1'b1) break;
        end
        `CHK(op_start_o, 1'b1)
    endtask
    task automatic wait_idle();
        repeat (3000) begin
            rd(OFS_STATUS);
            if (rv[BUSY_BIT] === 1'b0) break;
        end
        `CHK(rv[BUSY_BIT], 1'b0)
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(OFS_STATUS);
        `CHK(rv, 32'h0000_0000)
        rd(OFS_MODE);
        `CHK(rv, RST_MODE)
    endtask
    task automatic t_packet();
        eng_dly <= 8'h14;
        wr(OFS_MODE, 32'h0000_0001);
        wr(OFS_ADDR, 32'h0000_1002);
        wr(OFS_ARG, 32'h0000_0055);
        wr(OFS_FBWR, 32'h0000_00AB);
        wait_start();
        `CHK(op_mode_o, 4'h1)
        `CHK(op_addr_o, 32'h0000_1002)
        `CHK(op_arg_o, 32'h0000_0055)
        `CHK(op_word_o[23:16], 8'hAB)
        `CHK(op_mask_o, 4'h4)
        `CHK(op_deep_o, 1'b0)
        rd(OFS_STATUS);
        `CHK(rv[BUSY_BIT], 1'b1)
        wait_idle();
    endtask
    task automatic t_double();
        eng_dly <= 8'h28;
        wr(OFS_ADDR, 32'h0000_0010);
        wr(OFS_CMD, 32'h0000_0001);
        wait_start();
        wr(OFS_ADDR, 32'h0000_0020);
        rd(OFS_ADDR);
        `CHK(rv, 32'h0000_0020)
        `CHK(op_addr_o, 32'h0000_0010)
        wr(OFS_CMD, 32'h0000_0002);
        rd(OFS_STATUS);
        `CHK(rv[COUNT_MSB:COUNT_LSB], 5'h01)
        wait_start();
        `CHK(op_addr_o, 32'h0000_0020)
        wait_idle();
    endtask
    task automatic t_barrier();
        eng_dly <= 8'h1E;
        wr(OFS_CMD, 32'h0000_0000);
        wait_start();
        wr(OFS_STATUS, 32'h0000_0000);
        wr(OFS_DEPTH, 32'h0000_0001);
        wr(OFS_MODE, 32'h0000_0061);
        wr(OFS_FBWR, 32'h0012_3456);
        rd(OFS_DEPTH);
        `CHK(rv[DEEP_BIT], 1'b0)
        wait_start();
        `CHK(op_deep_o, 1'b1)
        `CHK(op_word_o[23:0], 24'h12_3456)
        wait_idle();
    endtask
    task automatic t_layouts();
        logic [31:0] msk [5] = '{32'h0000_00FF, 32'h0000_FF00, 32'h00FF_0000,
                                 32'h000F_0F0F, 32'h00F0_F0F0};
        logic [31:0] want [5] = '{32'h0000_00C3, 32'h0000_C300, 32'h00C3_0000,
                                  32'h000A_0C03, 32'h00A0_C030};
        logic [3:0]  lanes [3] = '{4'h9, 4'hA, 4'hC};
        eng_dly <= 8'h02;
        for (int k = 0; k < 5; k++) begin
            wr(OFS_MODE, 32'h0000_0001 | 32'((k + 1) << LAYOUT_LSB));
            wr(OFS_FBWR, 32'h0000_0AC3);
            wait_start();
            `CHK(op_word_o & msk[k], want[k])
            if (k < 3) `CHK(op_mask_o, lanes[k])
        end
        wr(OFS_MODE, 32'h0000_0071);
        n = n_starts;
        wr(OFS_CMD, 32'hAB12_3456);
        repeat (5) @(posedge clk_i);
        `CHK(n_starts, n)
        rd(OFS_STATUS);
        `CHK(rv[ERR_BIT], 1'b1)
        wr(OFS_MODE, 32'h0000_0079);
        wr(OFS_CMD, 32'hAB12_3456);
        wait_start();
        `CHK(op_word_o, 32'hAB12_3456)
        wr(OFS_MODE, 32'h0000_4079);
        wr(OFS_CMD, 32'h0000_5678);
        wait_start();
        `CHK(op_mode_o, 4'h9)
        wait_idle();
    endtask
    task automatic t_shallow();
        wr(OFS_STATUS, 32'h0000_0000);
        wr(OFS_DEPTH, 32'h0000_0000);
        wr(OFS_MODE, 32'h0000_0011);
        n = n_starts;
        wr(OFS_FBWR, 32'h0000_0001);
        repeat (5) @(posedge clk_i);
        `CHK(n_starts, n)
        rd(OFS_STATUS);
        `CHK(rv[ERR_BIT], 1'b1)
        wr(OFS_STATUS, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        rd(OFS_STATUS);
        `CHK(rv[ERR_BIT], 1'b0)
    endtask
    task automatic t_dma();
        eng_dly <= 8'h1E;
        wr(OFS_MODE, 32'h0000_0006);
        wr(OFS_CMD, 32'h0000_0000);
        wait_start();
        wr(OFS_XFER, 32'hDEAD_BEEF);
        repeat (5) @(posedge clk_i);
        `CHK(xfer_data_o, 32'h0000_0000)
        wait_idle();
        `CHK(xfer_data_o, 32'hDEAD_BEEF)
    endtask
    task automatic t_fill();
        eng_dly <= 8'h3C;
        wr(OFS_MODE, 32'h0000_0001);
        base = n_starts;
        n = 0;
        while (hold_o !== 1'b1 && n < 40) begin
            wr(OFS_CMD, 32'h0000_0000);
            n++;
            #1;
        end
        `CHK(n >= 16, 1'b1)
        rd(OFS_STATUS);
        `CHK(rv[COUNT_MSB:COUNT_LSB] >= 5'h0F, 1'b1)
        wait_idle();
        `CHK(n_starts - base, n)
    endtask

    task automatic close_out();
        $display("Mismatches %0d of %0d comparisons", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        resetn_i = 1'b0;
        wr_i     = 1'b0;
        rd_i     = 1'b0;
        addr_i   = 4'h0;
        wdata_i  = 32'h0000_0000;
        eng_dly  = 8'h02;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_packet();
        t_double();
        t_barrier();
        t_layouts();
        t_shallow();
        t_dma();
        t_fill();
        close_out();
    end
endmodule
